// ===== core/aoic_pkg.sv
// Package: constants and types for analog output mode and input calibration
// Notes on behaviour
// - Output mode 0..3: voltage_out_mode, 0-20, 4-20, fast
// - Unity voltage spans -10 V to +10 V
// - Voltage beyond 100 % saturates at limit
// - Current zero source gives range minimum
// - Current beyond 100 % held at 20 mA
// - Source times scale 0..4.000, default 1.000; fast refresh path runs at unity
// - Fast mode, designated source: fast refresh
// - Fast mode, other source: normal refresh
// - Both fast on speed/power: ignore second
// - Fast mode always drives voltage
// - Calibrate only below 1.5 V or above 2.5 V
// - Calibration request clears itself when done
// - Above threshold: input plus trim is full scale
// - Below threshold: internal reference, no trim
// - Save calibration level at power-down
// - Window filter, 0..8.0 ms, default 4.0
// - Window never shorter than 250 us
// - Resolution counts = sample time x 500 x 10, zero while the input is a speed reference
package aoic_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SAMPLE_US = 250;
  localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0] NORM_DIV_LAST = 3'h7;
  localparam logic [7:0] A_OUT1_MODE = 8'h00;
  localparam logic [7:0] A_OUT1_SEL = 8'h04;
  localparam logic [7:0] A_OUT1_SCALE = 8'h08;
  localparam logic [7:0] A_OUT2_MODE = 8'h0C;
  localparam logic [7:0] A_OUT2_SEL = 8'h10;
  localparam logic [7:0] A_OUT2_SCALE = 8'h14;
  localparam logic [7:0] A_CAL_CTRL = 8'h18;
  localparam logic [7:0] A_WINDOW = 8'h1C;
  localparam logic [7:0] A_FS_LEVEL = 8'h20;
  localparam logic [7:0] A_RESOLUTION = 8'h24;
  localparam logic [7:0] A_OUT_STATUS = 8'h28;
  localparam logic [15:0] SRC1_RST = 16'h0302;
  localparam logic [15:0] SRC2_RST = 16'h0402;
  localparam logic [15:0] FAST_SRC_SPEED = 16'h0302;
  localparam logic [15:0] FAST_SRC_POWER = 16'h0526;
  localparam int SCALE_FRAC = 12;
  localparam logic [15:0] SCALE_RST = 16'h1000;
  localparam logic [15:0] SCALE_MAX = 16'h4000;
  localparam logic [15:0] WIN_RST = 16'h0028;
  localparam logic [15:0] WIN_MAX = 16'h0050;
  localparam logic [15:0] RES_PER_TENTH = 16'h01F4;
  localparam int WIN_N_MAX = 32;
  localparam int FS_MV = 10000;
  localparam logic signed [15:0] FS_CODE = 16'sh7FFF;
  localparam logic signed [15:0] THR_LO = 16'(1500 * 32767 / FS_MV);
  localparam logic signed [15:0] THR_HI = 16'(2500 * 32767 / FS_MV);
  localparam logic signed [15:0] FS_REF = 16'(9800 * 32767 / FS_MV);
  localparam logic [15:0] I4_CODE = 16'(32767 / 5);
  localparam logic [31:0] I_SPAN = 32'(32767 * 4 / 5);
  typedef enum logic [1:0] {AOIC_VOLTAGE_OUT_MODE, AOIC_I0_20, AOIC_I4_20, AOIC_FAST} aoic_mode_t;
  typedef enum logic [1:0] {AOIC_CAL_IDLE, AOIC_CAL_WAIT} aoic_cal_t;
endpackage : aoic_pkg

// ===== core/aoic_filt_if.sv
// Interface: sample stream between control and window filter
`timescale 1ns/1ps
interface aoic_filt_if;
  logic signed [15:0] smp;
  logic smp_vld;
  logic [5:0] win_n;
  logic signed [15:0] avg;
  logic avg_vld;
  modport ctrl (output smp, output smp_vld, output win_n, input avg, input avg_vld);
  modport filt (input smp, input smp_vld, input win_n, output avg, output avg_vld);
endinterface : aoic_filt_if

// ===== core/aoic_filter.sv
// Module: moving-window average of the first analog input
`timescale 1ns/1ps
module aoic_filter import aoic_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  aoic_filt_if.filt f
);
  typedef struct packed {
    logic [4:0] wp;
    logic [5:0] fill;
    logic [5:0] n;
    logic signed [21:0] sum;
    logic signed [15:0] avg;
    logic vld;
  } aoic_filt_st_t;
  aoic_filt_st_t s_q, s_d;
  logic signed [15:0] mem_q [WIN_N_MAX];
  logic [16:0] recip [1:WIN_N_MAX];
  logic signed [15:0] oldest;
  logic signed [39:0] prod;

  // Reciprocals avoid a run-time divider
  for (genvar g = 1; g <= WIN_N_MAX; g++) begin : g_recip
    assign recip[g] = 17'(65536 / g);
  end

  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    prod = '0;
    // Slot wp - n is the sample leaving the window; n = 32 wraps onto wp
    oldest = (s_q.fill >= s_q.n) ? mem_q[5'(s_q.wp - s_q.n[4:0])] : '0;
    if (f.win_n != s_q.n) begin
      // New length restarts the window rather than mixing two lengths
      s_d.n = f.win_n;
      s_d.fill = '0;
      s_d.sum = '0;
    end else if (f.smp_vld) begin
      s_d.sum = s_q.sum + 22'(f.smp) - 22'(oldest);
      s_d.wp = s_q.wp + 5'h1;
      if (s_q.fill < s_q.n) begin
        s_d.fill = s_q.fill + 6'h1;
      end
      prod = s_d.sum * $signed({23'h0, recip[s_q.n]});
      s_d.avg = 16'(prod >>> 16);
      s_d.vld = s_d.fill >= s_q.n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{wp: '0, fill: '0, n: 6'h1, sum: '0, avg: '0, vld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (f.smp_vld && f.win_n == s_q.n) begin
      mem_q[s_q.wp] <= f.smp;
    end
  end

  assign f.avg = s_q.avg;
  assign f.avg_vld = s_q.vld;

  a_win_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.n >= 6'h1 && s_q.n <= 6'(WIN_N_MAX))
    else $error("filter window length out of range");
endmodule : aoic_filter

// ===== core/aoic_ctrl.sv
// Module: analog output modes, scaling and input full-scale calibration
`timescale 1ns/1ps
module aoic_ctrl import aoic_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] out1_src_sel_o,
  output logic [15:0] out2_src_sel_o,
  input wire logic signed [15:0] out1_src_val_i,
  input wire logic signed [15:0] out2_src_val_i,
  output logic [15:0] out1_code_o,
  output logic [15:0] out2_code_o,
  output logic out1_current_o,
  output logic out2_current_o,
  output logic out1_fast_o,
  output logic out2_fast_o,
  input wire logic signed [15:0] adc_smp_i,
  input wire logic signed [15:0] offset_trim_i,
  input wire logic speed_ref_i,
  input wire logic power_fail_i,
  input wire logic nv_load_i,
  input wire logic [15:0] nv_level_i,
  output logic nv_store_o,
  output logic [15:0] nv_level_o
);
  // All state in one record; next-state logic fills s_d
  typedef struct packed {
    aoic_mode_t [1:0] mode;
    logic [1:0][15:0] sel;
    logic [1:0][15:0] scale;
    logic cal_req;
    logic cal_refused;
    aoic_cal_t cal;
    logic [15:0] win;
    logic signed [15:0] fs;
    logic [1:0][15:0] code;
    logic [1:0] cur;
    logic [1:0] fast;
    logic [15:0] tick_cnt;
    logic [2:0] div_cnt;
    logic smp_tick;
    logic norm_tick;
    logic ack;
    logic [31:0] dat;
    logic [2:0] pf_sync;
    logic pf_state;
    logic nv_store;
  } aoic_ctrl_st_t;

  aoic_ctrl_st_t s_q, s_d;
  aoic_filt_if fif ();
  logic [1:0] desig;
  logic [1:0] fast_ok;
  logic [1:0][15:0] val;
  logic wr;
  logic [31:0] wdat;
  logic [7:0] a;

  // Clamp a wide product into the converter code range
  function automatic logic [15:0] sat16(input logic signed [33:0] p, input logic signed [15:0] lo);
    if (p > 34'(FS_CODE)) begin
      sat16 = FS_CODE;
    end else if (p < 34'(lo)) begin
      sat16 = lo;
    end else begin
      sat16 = 16'(p);
    end
  endfunction : sat16

  function automatic logic [15:0] drive_code(input aoic_mode_t m, input logic signed [15:0] v,
                                             input logic [15:0] sc, input logic fst);
    logic signed [33:0] p;
    logic [15:0] c;
    // Fast path runs at unity scale; user scale applies only at normal rate
    p = fst ? 34'(v) : (34'(v) * $signed({18'h0, sc})) >>> SCALE_FRAC;
    c = '0;
    case (m)
      AOIC_I0_20: begin
        drive_code = sat16(p, 16'sh0000);
      end
      AOIC_I4_20: begin
        c = sat16(p, 16'sh0000);
        // Truncated span stops short of the top code, so the ceiling is pinned
        if (c == 16'(FS_CODE)) begin
          drive_code = 16'(FS_CODE);
        end else begin
          drive_code = I4_CODE + 16'((32'(c) * I_SPAN) >> 15);
        end
      end
      default: begin
        // Fast mode lands here too, so it is always a voltage
        drive_code = sat16(p, -FS_CODE);
      end
    endcase
  endfunction : drive_code

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction : merge

  // Only speed and power qualify for the fast path
  function automatic logic is_fast_src(input logic [15:0] s);
    is_fast_src = s == FAST_SRC_SPEED || s == FAST_SRC_POWER;
  endfunction : is_fast_src

  function automatic logic [5:0] win_len(input logic [15:0] w);
    logic [16:0] n;
    // Tenths of ms to whole 250 us periods, nearest
    n = (17'(w) * 17'h2 + 17'h2) / 17'h5;
    win_len = (n == 17'h0) ? 6'h1 : 6'(n);
  endfunction : win_len

  assign val[0] = out1_src_val_i;
  assign val[1] = out2_src_val_i;
  // Qualification goes by the select value alone
  assign desig[0] = is_fast_src(s_q.sel[0]);
  assign desig[1] = is_fast_src(s_q.sel[1]);
  assign fast_ok[0] = s_q.mode[0] == AOIC_FAST && desig[0];
  // Every designated source is speed or power, so any fast output 1 blocks output 2
  assign fast_ok[1] = s_q.mode[1] == AOIC_FAST && desig[1] && !fast_ok[0];
  assign a = {wb_adr_i[7:2], 2'b00};
  // Write lands on the edge where the master sees ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;

  always_comb begin
    s_d = s_q;
    wdat = '0;
    s_d.nv_store = 1'b0;
    s_d.smp_tick = 1'b0;
    s_d.norm_tick = 1'b0;
    // Sample tick every 250 us, normal refresh every eighth tick
    if (s_q.tick_cnt == 16'(SAMPLE_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.smp_tick = 1'b1;
      s_d.div_cnt = s_q.div_cnt + 3'h1;
      s_d.norm_tick = s_q.div_cnt == NORM_DIV_LAST;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h1;
    end
    for (int i = 0; i < 2; i++) begin
      if (fast_ok[i] ? s_q.smp_tick : s_q.norm_tick) begin
        s_d.code[i] = drive_code(s_q.mode[i], val[i], s_q.scale[i], fast_ok[i]);
        s_d.cur[i] = s_q.mode[i] == AOIC_I0_20 || s_q.mode[i] == AOIC_I4_20;
        s_d.fast[i] = fast_ok[i];
      end
    end
    // Calibration waits for the next full-window average
    if (s_q.cal == AOIC_CAL_IDLE) begin
      if (s_q.cal_req) begin
        s_d.cal = AOIC_CAL_WAIT;
      end
    end else if (fif.avg_vld) begin
      if (fif.avg > THR_HI) begin
        s_d.fs = 16'(sat16(34'(fif.avg) + 34'(offset_trim_i), 16'sh0001));
      end else if (fif.avg < THR_LO) begin
        s_d.fs = FS_REF;
      end else begin
        s_d.cal_refused = 1'b1;
      end
      s_d.cal_req = 1'b0;
      s_d.cal = AOIC_CAL_IDLE;
    end
    // Restored level overrides a calibration in the same cycle
    if (nv_load_i) begin
      s_d.fs = nv_level_i;
    end
    // Three-stage synchroniser; stage 0 feeds stage 1 only
    s_d.pf_sync = {s_q.pf_sync[1:0], power_fail_i};
    if (s_q.pf_sync[2] == s_q.pf_sync[1] && s_q.pf_sync[1] != s_q.pf_state) begin
      s_d.pf_state = s_q.pf_sync[1];
      s_d.nv_store = s_q.pf_sync[1];
    end
    // Single-cycle ack; a held request is acked and taken again every second cycle
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    if (wr) begin
      case (a)
        A_OUT1_MODE, A_OUT2_MODE: begin
          wdat = merge(32'(s_q.mode[a == A_OUT2_MODE]), wb_dat_i, wb_sel_i);
          s_d.mode[a == A_OUT2_MODE] = aoic_mode_t'(wdat[1:0]);
        end
        A_OUT1_SEL, A_OUT2_SEL: begin
          wdat = merge(32'(s_q.sel[a == A_OUT2_SEL]), wb_dat_i, wb_sel_i);
          s_d.sel[a == A_OUT2_SEL] = wdat[15:0];
        end
        A_OUT1_SCALE, A_OUT2_SCALE: begin
          wdat = merge(32'(s_q.scale[a == A_OUT2_SCALE]), wb_dat_i, wb_sel_i);
          s_d.scale[a == A_OUT2_SCALE] = (wdat[15:0] > SCALE_MAX) ? SCALE_MAX : wdat[15:0];
        end
        A_CAL_CTRL: begin
          // Write is ignored while a request is pending, so one written as the hardware clears it is lost
          if (wb_sel_i[0] && wb_dat_i[0] && !s_q.cal_req) begin
            s_d.cal_req = 1'b1;
            s_d.cal_refused = 1'b0;
          end
        end
        A_WINDOW: begin
          wdat = merge(32'(s_q.win), wb_dat_i, wb_sel_i);
          s_d.win = (wdat[15:0] > WIN_MAX) ? WIN_MAX : wdat[15:0];
        end
        default: begin
        end
      endcase
    end
    // Read data stands in the ack cycle only, zero otherwise
    s_d.dat = '0;
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack) begin
      case (a)
        A_OUT1_MODE: s_d.dat = 32'(s_q.mode[0]);
        A_OUT1_SEL: s_d.dat = 32'(s_q.sel[0]);
        A_OUT1_SCALE: s_d.dat = 32'(s_q.scale[0]);
        A_OUT2_MODE: s_d.dat = 32'(s_q.mode[1]);
        A_OUT2_SEL: s_d.dat = 32'(s_q.sel[1]);
        A_OUT2_SCALE: s_d.dat = 32'(s_q.scale[1]);
        A_CAL_CTRL: s_d.dat = {29'h0, s_q.cal == AOIC_CAL_WAIT, s_q.cal_refused, s_q.cal_req};
        A_WINDOW: s_d.dat = 32'(s_q.win);
        A_FS_LEVEL: s_d.dat = 32'(s_q.fs);
        // Resolution only meaningful when the input is not a speed reference
        A_RESOLUTION: s_d.dat = speed_ref_i ? 32'h0 : 32'(s_q.win) * 32'(RES_PER_TENTH);
        A_OUT_STATUS: s_d.dat = {28'h0, s_q.fast, s_q.cur};
        default: s_d.dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Zero first, then the defaults on top
      s_q <= '0;
      s_q.mode <= {AOIC_VOLTAGE_OUT_MODE, AOIC_VOLTAGE_OUT_MODE};
      s_q.sel <= {SRC2_RST, SRC1_RST};
      s_q.scale <= {SCALE_RST, SCALE_RST};
      s_q.win <= WIN_RST;
      s_q.fs <= FS_REF;
    end else begin
      s_q <= s_d;
    end
  end

  // Filter takes a sample on every sample tick
  assign fif.smp = adc_smp_i;
  assign fif.smp_vld = s_q.smp_tick;
  assign fif.win_n = win_len(s_q.win);

  aoic_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(fif.filt)
  );

  // Outputs straight from the state record
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign out1_src_sel_o = s_q.sel[0];
  assign out2_src_sel_o = s_q.sel[1];
  assign out1_code_o = s_q.code[0];
  assign out2_code_o = s_q.code[1];
  assign out1_current_o = s_q.cur[0];
  assign out2_current_o = s_q.cur[1];
  assign out1_fast_o = s_q.fast[0];
  assign out2_fast_o = s_q.fast[1];
  assign nv_store_o = s_q.nv_store;
  assign nv_level_o = s_q.fs;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Calibration outcomes
  a_cal_self_clear: assert property (s_q.cal == AOIC_CAL_WAIT && fif.avg_vld |=> !s_q.cal_req)
    else $error("calibration request not cleared");
  a_cal_band_refuse: assert property (s_q.cal == AOIC_CAL_WAIT && fif.avg_vld && !nv_load_i
    && fif.avg <= THR_HI && fif.avg >= THR_LO |=> s_q.cal_refused && $stable(s_q.fs))
    else $error("calibration taken inside forbidden band");
  a_cal_above_trim: assert property (s_q.cal == AOIC_CAL_WAIT && fif.avg_vld && !nv_load_i
    && fif.avg > THR_HI |=> s_q.fs == sat16(34'($past(fif.avg)) + 34'($past(offset_trim_i)), 16'sh0001))
    else $error("full scale not taken from input");
  a_cal_below_ref: assert property (s_q.cal == AOIC_CAL_WAIT && fif.avg_vld && !nv_load_i
    && fif.avg < THR_LO |=> s_q.fs == FS_REF)
    else $error("full scale not set from reference");

  // Output modes, clamps and refresh rates
  a_fast_is_voltage_out_mode: assert property (s_q.fast[0] || s_q.fast[1] |-> !(s_q.fast[0] && s_q.cur[0])
    && !(s_q.fast[1] && s_q.cur[1]))
    else $error("fast output driven as current");
  a_fast_mode_voltage_out_mode: assert property (s_q.norm_tick && s_q.mode[1] == AOIC_FAST |=> !s_q.cur[1])
    else $error("fast mode output not voltage");
  a_second_ignored: assert property (s_q.smp_tick && fast_ok[0] |=> !s_q.fast[1])
    else $error("second output fast despite first");
  a_voltage_out_mode_in_span: assert property (!s_q.cur[0] |-> s_q.code[0] != 16'h8000)
    else $error("voltage code beyond span");
  a_curr_floor: assert property (s_q.norm_tick && s_q.mode[0] == AOIC_I4_20
    |=> s_q.code[0] >= I4_CODE && s_q.code[0] <= 16'(FS_CODE))
    else $error("current code outside 4-20 range");
  a_curr_zero_floor: assert property (s_q.norm_tick && s_q.mode[0] == AOIC_I4_20 && val[0] == 16'h0000
    |=> s_q.code[0] == I4_CODE)
    else $error("zero source not at the 4 mA code");
  a_curr_ceiling: assert property (s_q.norm_tick && s_q.mode[0] == AOIC_I4_20 && val[0] == 16'h7FFF
    && s_q.scale[0] >= SCALE_RST |=> s_q.code[0] == 16'(FS_CODE))
    else $error("full source not at the 20 mA code");
  a_curr_mode_drive: assert property (s_q.norm_tick && s_q.mode[0] inside {AOIC_I0_20, AOIC_I4_20}
    |=> s_q.cur[0])
    else $error("current mode not driven as current");
  a_normal_rate: assert property (!s_q.norm_tick && !fast_ok[0] |=> $stable(s_q.code[0]))
    else $error("normal-rate output changed off its tick");
  a_fast_refresh: assert property (s_q.smp_tick && fast_ok[1] |=> s_q.fast[1] && !s_q.cur[1])
    else $error("fast output not refreshed as voltage");
  a_fast_off_tick: assert property (!s_q.smp_tick |=> $stable(s_q.code[1]))
    else $error("output changed between sample ticks");
  a_tick_single: assert property (s_q.smp_tick |=> !s_q.smp_tick)
    else $error("sample tick longer than one cycle");

  // Power-down store
  a_store_powerdn: assert property (s_q.pf_sync[2] && s_q.pf_sync[1] && !s_q.pf_state
    |=> s_q.nv_store ##1 !s_q.nv_store)
    else $error("no single store pulse at power-down");

  // Register bus and settings
  a_ack_pulse: assert property (s_q.ack |=> !s_q.ack)
    else $error("acknowledge held beyond one cycle");
  a_rd_data_idle: assert property (!s_q.ack |-> s_q.dat == 32'h0)
    else $error("read data outside the acknowledge cycle");
  a_scale_in_range: assert property (s_q.scale[0] <= SCALE_MAX && s_q.scale[1] <= SCALE_MAX)
    else $error("scale above its ceiling");
  a_win_in_range: assert property (s_q.win <= WIN_MAX)
    else $error("window setting above its ceiling");

  c_fast_out1: cover property (s_q.smp_tick && fast_ok[0] ##1 s_q.fast[0]);
  c_cal_above: cover property (s_q.cal == AOIC_CAL_WAIT && fif.avg_vld && fif.avg > THR_HI);
  c_cal_refused: cover property ($rose(s_q.cal_refused));
  c_power_store: cover property (s_q.nv_store);
  c_second_fast: cover property (s_q.smp_tick && fast_ok[1] ##1 s_q.fast[1]);
endmodule : aoic_ctrl

// ===== bench/aoic_conv_model.sv
// Model of the drive source mux and the input-1 converter
`timescale 1ns/1ps
module aoic_conv_model (
  input wire logic clk_i,
  input wire logic [15:0] sel1_i,
  input wire logic [15:0] sel2_i,
  input wire logic signed [15:0] v1_i,
  input wire logic signed [15:0] v2_i,
  input wire logic signed [15:0] lvl_i,
  output logic signed [15:0] src1_o,
  output logic signed [15:0] src2_o,
  output logic signed [15:0] adc_o
);
  // Mux answers one clock late; a null selection reads as zero
  always_ff @(posedge clk_i) begin
    src1_o <= (sel1_i == 16'h0000) ? 16'sh0000 : v1_i;
    src2_o <= (sel2_i == 16'h0000) ? 16'sh0000 : v2_i;
    adc_o <= lvl_i;
  end
endmodule : aoic_conv_model

// ===== bench/test_analog_output_mode_and_input_calibration.sv
// Testbench: output modes, scaling, calibration and window settings
`timescale 1ns/1ps
module test_analog_output_mode_and_input_calibration;
  import aoic_pkg::*;
  localparam int SC = 20;
  localparam logic [7:0] ADR_T [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
    8'h28, 8'h3C};
  localparam logic [31:0] RST_T [12] = '{32'h0, 32'h0302, 32'h1000, 32'h0, 32'h0402, 32'h1000, 32'h0, 32'h0028,
    {16'h0000, FS_REF}, 32'h4E20, 32'h0, 32'h0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rq;
  logic ack;
  logic [15:0] sel1, sel2, c1, c2, nvl;
  logic cur1, cur2, f1, f2, nvs;
  logic signed [15:0] v1 = 16'sh0, v2 = 16'sh0, lvl = 16'sh0, trim = 16'sh0, s1, s2, adc;
  logic sref = 1'b0;
  logic pf = 1'b0;
  logic nvld = 1'b0;
  logic [15:0] nvin = 16'h0000;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  aoic_ctrl #(.SAMPLE_CYCLES(SC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .out1_src_sel_o(sel1), .out2_src_sel_o(sel2), .out1_src_val_i(s1), .out2_src_val_i(s2),
    .out1_code_o(c1), .out2_code_o(c2), .out1_current_o(cur1), .out2_current_o(cur2), .out1_fast_o(f1),
    .out2_fast_o(f2), .adc_smp_i(adc), .offset_trim_i(trim), .speed_ref_i(sref), .power_fail_i(pf),
    .nv_load_i(nvld), .nv_level_i(nvin), .nv_store_o(nvs), .nv_level_o(nvl));

  aoic_conv_model u_conv (.clk_i(clk_i), .sel1_i(sel1), .sel2_i(sel2), .v1_i(v1), .v2_i(v2), .lvl_i(lvl),
    .src1_o(s1), .src2_o(s2), .adc_o(adc));

  task automatic fail(input string m);
    bad_count++;
    $display("Error at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
  endtask : chk_rd

  task automatic chk_out(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("output %h, expected %h", got, exp));
  endtask : chk_out

  // Read checks come from the queue, in request order
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk_rd(rdat & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  // Eight sample ticks make one normal refresh, so 400 cycles always spans one
  task automatic out_chk(input logic [17:0] e1, input logic [17:0] e2);
    repeat (400) @(posedge clk_i);
    chk_out({c1, cur1, f1}, e1);
    chk_out({c2, cur2, f2}, e2);
  endtask : out_chk

  task automatic step(input logic [1:0] m, input logic [15:0] s, input int v, input logic [17:0] e);
    wr(A_OUT1_MODE, {30'h0, m});
    wr(A_OUT1_SCALE, {16'h0, s});
    v1 <= 16'(v);
    out_chk(e, 18'h0);
  endtask : step

  task automatic cal(input logic [15:0] efs, input logic eref);
    int n;
    n = 0;
    repeat (300) @(posedge clk_i);
    wr(A_CAL_CTRL, 32'h1);
    do begin
      rd(A_CAL_CTRL, 32'hFFFF_FFF8, 32'h0);
      n++;
    end while (rq[0] !== 1'b0 && n < 200);
    if (n >= 200) fail("calibration hung");
    rd(A_CAL_CTRL, 32'h3, {30'h0, eref, 1'b0});
    rd(A_FS_LEVEL, 32'hFFFF_FFFF, {16'h0, efs});
  endtask : cal

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge clk_i);
    fail("watchdog expired");
    close_out();
  end

  initial begin
    int r;
    void'($urandom(32'hBE51));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) rd(ADR_T[i], 32'hFFFF_FFFF, RST_T[i]);
    wr(A_OUT1_SCALE, 32'h5000);
    rd(A_OUT1_SCALE, 32'hFFFF_FFFF, 32'h4000);
    wb(1'b1, A_OUT2_SCALE, 32'h0000_2000, 4'h2);
    rd(A_OUT2_SCALE, 32'hFFFF_FFFF, 32'h2000);
    wr(A_WINDOW, 32'h60);
    rd(A_WINDOW, 32'hFFFF_FFFF, 32'h50);
    rd(A_RESOLUTION, 32'hFFFF_FFFF, 32'h9C40);
    wr(A_WINDOW, 32'h0A);
    rd(A_RESOLUTION, 32'hFFFF_FFFF, 32'h1388);
    sref <= 1'b1;
    rd(A_RESOLUTION, 32'hFFFF_FFFF, 32'h0);
    sref <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      r = int'($urandom_range(65534)) - 32767;
      step(2'd0, 16'h1000, r, {16'(r), 2'b00});
    end
    step(2'd1, 16'h1000, 1000, {16'd1000, 2'b10});
    step(2'd1, 16'h1000, -500, {16'd0, 2'b10});
    step(2'd2, 16'h1000, 0, {I4_CODE, 2'b10});
    step(2'd2, 16'h4000, 32767, {16'h7FFF, 2'b10});
    step(2'd0, 16'h4000, 10000, {16'h7FFF, 2'b00});
    step(2'd0, 16'h2000, -10000, {16'hB1E0, 2'b00});
    step(2'd3, 16'h2000, 20000, {16'd20000, 2'b01});
    wr(A_OUT2_MODE, 32'h3);
    wr(A_OUT2_SEL, 32'h0526);
    v2 <= 16'sd3000;
    out_chk({16'd20000, 2'b01}, {16'd6000, 2'b00});
    wr(A_OUT1_SEL, 32'h0100);
    out_chk({16'h7FFF, 2'b00}, {16'd3000, 2'b01});
    v2 <= -16'sd3000;
    repeat (3 * SC + 4) @(posedge clk_i);
    chk_out({c2, cur2, f2}, {16'hF448, 2'b01});
    trim <= 16'sd100;
    lvl <= 16'sd20000;
    wr(A_WINDOW, 32'h0);
    cal(16'd20100, 1'b0);
    wr(A_WINDOW, 32'h0A);
    lvl <= 16'sd6000;
    cal(16'd20100, 1'b1);
    lvl <= 16'sd3000;
    cal(FS_REF, 1'b0);
    nvin <= 16'h1234;
    nvld <= 1'b1;
    @(posedge clk_i);
    nvld <= 1'b0;
    rd(A_FS_LEVEL, 32'hFFFF_FFFF, 32'h1234);
    pf <= 1'b1;
    r = 0;
    do begin
      @(posedge clk_i);
      r++;
    end while (nvs !== 1'b1 && r < 10);
    chk_out({nvl, nvs, 1'b0}, {16'h1234, 2'b10});
    close_out();
  end
endmodule : test_analog_output_mode_and_input_calibration
